// *** design/line_error_jitter_regs.vh ***
// Summary of operation
// - Bit 5 latches single bipolar violation, bit 4 latches line bipolar violation.
// - Bit 3 latches single excess zeros, bit 2 latches line excess zeros.
// - Bit 1 latches a test pattern bit error.
// - Bit 0 latches an overflow of the 16-bit error counter.
// - Status flags reset to zero; writing one clears, writing zero keeps.
// - Interrupt output is high while any enabled status flag is set.
// - Status bits 7 and 6 are reserved and read zero.
// - Error count is 16 bits over read-only low and high bytes, reset zero.
// - Counter value moves to count registers automatically or on request, per mode bit.
// - Count pair per channel 1 to 16 at stride 0x40, plus channel 0 pair.
// - In manual period mode, a rising stop bit copies latest positive and negative peak jitter results.
// - Period mode bit: zero manual period ended by stop, one automatic one second.
// - Bandwidth bit selects the jitter measurement band.
// - Jitter configuration is channel 0 only, one address, reset zero, bits 7-3 reserved.
// - Peak results are 12 bits, low byte plus four-bit high register.
`ifndef LINE_ERROR_JITTER_REGS_VH
`define LINE_ERROR_JITTER_REGS_VH

`define OFF_STATUS        6'h22
`define OFF_COUNT_LOW     6'h23
`define OFF_COUNT_HIGH    6'h24
`define OFF_COUNT_CTRL    6'h3e
`define OFF_IRQ_MASK      6'h3f

`define ADDR_CH0_COUNT_LOW   11'h7e3
`define ADDR_CH0_COUNT_HIGH  11'h7e4
`define ADDR_JITTER_CONFIG   11'h7e5
`define ADDR_POS_PEAK_LOW    11'h7e6
`define ADDR_POS_PEAK_HIGH   11'h7e7
`define ADDR_NEG_PEAK_LOW    11'h7e8
`define ADDR_NEG_PEAK_HIGH   11'h7e9
`define ADDR_CH0_COUNT_CTRL  11'h7ea

`define BIT_SINGLE_BPV    5
`define BIT_LINE_BPV      4
`define BIT_SINGLE_EXZ    3
`define BIT_LINE_EXZ      2
`define BIT_PATTERN_ERR   1
`define BIT_CNT_OVERFLOW  0

`define BIT_MEAS_STOP     2
`define BIT_MEAS_MODE     1
`define BIT_MEAS_BW       0
`define BIT_CNT_MODE      1
`define BIT_CNT_REQUEST   0

`define STATUS_RESET      6'h00
`define STATUS_USED       8'h3f
`define MASK_RESET        6'h3f
`define JITTER_RESET      3'h0
`define COUNT_RESET       16'h0000
`define COUNT_MAX         16'hffff
`define PEAK_RESET        12'h000

`define CLK_FREQ_KHZ      125000
`define ROUND_TIME_MS     1000
// Time in ms times clock in kHz, kept at counter width
`define ROUND_CYCLES      27'h7735940
`define JITTER_TIME_MS    1000
`define JITTER_CYCLES     27'h7735940

`endif

// *** design/line_error_jitter_status_regs.v ***
`timescale 1ns/1ps
`include "line_error_jitter_regs.vh"

module line_error_jitter_status_regs #(
    parameter [26:0] ROUND_CYCLES  = `ROUND_CYCLES,
    parameter [26:0] JITTER_CYCLES = `JITTER_CYCLES
) (
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire [10:0] addr,
    input  wire [7:0]  wrData,
    input  wire        wrStrobe,
    input  wire        rdStrobe,
    output reg  [7:0]  rdData,
    input  wire [15:0] singleBipolarViolation,
    input  wire [15:0] lineBipolarViolation,
    input  wire [15:0] singleExcessZeros,
    input  wire [15:0] lineExcessZeros,
    input  wire [15:0] patternError,
    input  wire [16:0] errorEvent,
    input  wire [11:0] posPeakIn,
    input  wire [11:0] negPeakIn,
    output wire        measBandwidthSelect,
    output wire        measPeriodMode,
    output reg         measPeriodEnd,
    output wire        irq
);

    // Channel n (1..16) owns the 64-byte window starting at (n-1)*0x40
    function chanHit;
        input [10:0] a;
        input [4:0]  chan;
        begin
            chanHit = (chan != 5'd0) && (a[10] == 1'b0) && ({1'b0, a[9:6]} == (chan - 5'd1));
        end
    endfunction

    // Per-channel register decode, shared by the channel 1..16 write paths
    function regHit;
        input [10:0] a;
        input [4:0]  chan;
        input [5:0]  off;
        begin
            regHit = chanHit(a, chan) && (a[5:0] == off);
        end
    endfunction

    // Count control readback: the request bit is a pulse and reads zero
    function [7:0] ctrlByte;
        input mode;
        begin
            ctrlByte = {6'h00, mode, 1'b0};
        end
    endfunction

    function [7:0] flagByte;
        input [5:0] flags;
        begin
            flagByte = {2'b00, flags};
        end
    endfunction

    function [7:0] countByte;
        input [15:0] count;
        input        upper;
        begin
            countByte = upper ? count[15:8] : count[7:0];
        end
    endfunction

    // Upper result nibble; reserved bits read zero
    function [7:0] peakHighByte;
        input [11:0] peak;
        begin
            peakHighByte = {4'h0, peak[11:8]};
        end
    endfunction

    // Terminal counts at counter width, so the compares need no padding
    localparam [26:0] ROUND_LAST  = ROUND_CYCLES - 27'h0000001;
    localparam [26:0] JITTER_LAST = JITTER_CYCLES - 27'h0000001;

    // Shared counting round for automatic error count updates
    reg  [26:0] roundCnt;
    reg         roundEnd;
    wire        roundWrap;

    assign roundWrap = (roundCnt >= ROUND_LAST);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            roundCnt <= 27'h0000000;
            roundEnd <= 1'b0;
        end else if (roundWrap) begin
            roundCnt <= 27'h0000000;
            roundEnd <= 1'b1;
        end else begin
            roundCnt <= roundCnt + 27'h0000001;
            roundEnd <= 1'b0;
        end
    end

    // Per-channel error counters; index 0 is channel 0
    wire [17*16-1:0] shownAll;
    wire [16:0]      cntModeAll;
    // Channel 0 has no status register, so its overflow bit goes unread
    wire [16:0]      overflowAll;

    genvar i;
    generate
        for (i = 0; i < 17; i = i + 1) begin : g_count
            reg  [15:0] liveCount;
            reg  [15:0] shownCount;
            reg         cntMode;
            reg         overflowPulse;
            wire        ctrlHit;
            wire        manualReq;
            wire        update;
            wire        atMax;

            if (i == 0) begin : g_ch0
                assign ctrlHit = wrStrobe && (addr == `ADDR_CH0_COUNT_CTRL);
            end else begin : g_chn
                assign ctrlHit = wrStrobe && regHit(addr, i[4:0], `OFF_COUNT_CTRL);
            end

            // Request bit is a write-only pulse, never stored
            assign manualReq = ctrlHit && wrData[`BIT_CNT_REQUEST];
            // Requests are ignored in auto mode, so the round is the only source
            assign update    = cntMode ? roundEnd : manualReq;
            assign atMax     = (liveCount == `COUNT_MAX);

            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    cntMode <= 1'b0;
                end else if (ctrlHit) begin
                    cntMode <= wrData[`BIT_CNT_MODE];
                end
            end

            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    liveCount     <= `COUNT_RESET;
                    shownCount    <= `COUNT_RESET;
                    overflowPulse <= 1'b0;
                end else if (update) begin
                    // New round starts; an error in this cycle opens it
                    shownCount    <= liveCount;
                    liveCount     <= errorEvent[i] ? 16'h0001 : `COUNT_RESET;
                    overflowPulse <= 1'b0;
                end else if (errorEvent[i]) begin
                    if (atMax) begin
                        // Saturate rather than wrap so the shown value stays meaningful
                        overflowPulse <= 1'b1;
                    end else begin
                        liveCount     <= liveCount + 16'h0001;
                        overflowPulse <= 1'b0;
                    end
                end else begin
                    overflowPulse <= 1'b0;
                end
            end

            assign shownAll[16*i +: 16] = shownCount;
            assign cntModeAll[i]        = cntMode;
            assign overflowAll[i]       = overflowPulse;
        end
    endgenerate

    // Per-channel sticky status and mask, channels 1..16
    wire [16*8-1:0] statusAll;
    wire [16*8-1:0] maskAll;
    wire [15:0]     chanIrq;

    generate
        for (i = 1; i < 17; i = i + 1) begin : g_status
            reg  [5:0] status;
            reg  [5:0] mask;
            wire [5:0] setBits;
            wire [5:0] clrBits;
            wire       statusWr;
            wire       maskWr;
            wire [5:0] pending;

            assign statusWr = wrStrobe && regHit(addr, i[4:0], `OFF_STATUS);
            assign maskWr   = wrStrobe && regHit(addr, i[4:0], `OFF_IRQ_MASK);

            assign setBits[`BIT_SINGLE_BPV]   = singleBipolarViolation[i-1];
            assign setBits[`BIT_LINE_BPV]     = lineBipolarViolation[i-1];
            assign setBits[`BIT_SINGLE_EXZ]   = singleExcessZeros[i-1];
            assign setBits[`BIT_LINE_EXZ]     = lineExcessZeros[i-1];
            assign setBits[`BIT_PATTERN_ERR]  = patternError[i-1];
            assign setBits[`BIT_CNT_OVERFLOW] = overflowAll[i];

            assign clrBits = statusWr ? wrData[5:0] : 6'h00;

            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    status <= `STATUS_RESET;
                end else begin
                    // Set beats clear so an event in the clearing cycle survives
                    status <= (status & ~clrBits) | setBits;
                end
            end

            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    // All enabled, so any set flag reaches irq without setup
                    mask <= `MASK_RESET;
                end else if (maskWr) begin
                    mask <= wrData[5:0];
                end
            end

            assign statusAll[8*(i-1) +: 8] = flagByte(status);
            assign maskAll[8*(i-1) +: 8]   = flagByte(mask);
            assign pending                 = status & mask;
            assign chanIrq[i-1]            = |pending;
        end
    endgenerate

    assign irq = |chanIrq;

    // Channel 0 jitter measurement configuration and results
    reg  [2:0]  jitterCfg;
    reg         stopPrev;
    reg  [26:0] jitterCnt;
    reg  [11:0] posPeak;
    reg  [11:0] negPeak;
    wire        jitterCfgWr;
    wire        stopRise;
    wire        autoTick;
    wire        capture;
    wire        stopLevel;
    wire        jitterWrap;

    assign jitterCfgWr = wrStrobe && (addr == `ADDR_JITTER_CONFIG);

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            jitterCfg <= `JITTER_RESET;
        end else if (jitterCfgWr) begin
            jitterCfg <= wrData[2:0];
        end
    end

    assign measPeriodMode      = jitterCfg[`BIT_MEAS_MODE];
    assign measBandwidthSelect = jitterCfg[`BIT_MEAS_BW];
    assign stopLevel           = jitterCfg[`BIT_MEAS_STOP];

    // Edge, not level: software must drop the bit to arm the next stop
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            stopPrev <= 1'b0;
        end else begin
            stopPrev <= stopLevel;
        end
    end

    assign stopRise = stopLevel && !stopPrev && !measPeriodMode;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            jitterCnt <= 27'h0000000;
        end else if (!measPeriodMode) begin
            jitterCnt <= 27'h0000000;
        end else if (jitterWrap) begin
            jitterCnt <= 27'h0000000;
        end else begin
            jitterCnt <= jitterCnt + 27'h0000001;
        end
    end

    // Counter idles at zero in manual mode, so an auto period starts on the mode write
    assign jitterWrap = (jitterCnt >= JITTER_LAST);
    assign autoTick   = measPeriodMode && jitterWrap;
    assign capture  = stopRise || autoTick;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            posPeak       <= `PEAK_RESET;
            negPeak       <= `PEAK_RESET;
            measPeriodEnd <= 1'b0;
        end else begin
            measPeriodEnd <= capture;
            if (capture) begin
                posPeak <= posPeakIn;
                negPeak <= negPeakIn;
            end
        end
    end

    // Read path: data in the cycle after the strobe, zero elsewhere
    reg  [7:0]  next_rdData;
    reg  [3:0]  chIdx;
    reg  [8:0]  shownBase;
    reg  [6:0]  byteBase;
    reg  [15:0] shownSel;
    wire        chanSpace;

    // Channel windows fill the lower half of the map; the upper half is channel 0 only
    assign chanSpace = (addr[10] == 1'b0);

    always @* begin
        next_rdData = 8'h00;
        chIdx       = addr[9:6];
        byteBase    = {chIdx, 3'b000};
        shownBase   = {1'b0, chIdx, 4'h0} + 9'h010;
        shownSel    = shownAll[shownBase +: 16];
        if (chanSpace) begin
            case (addr[5:0])
                `OFF_STATUS: begin
                    next_rdData = statusAll[byteBase +: 8];
                end
                `OFF_COUNT_LOW: begin
                    next_rdData = countByte(shownSel, 1'b0);
                end
                `OFF_COUNT_HIGH: begin
                    next_rdData = countByte(shownSel, 1'b1);
                end
                `OFF_COUNT_CTRL: begin
                    next_rdData = ctrlByte(cntModeAll[chIdx + 5'd1]);
                end
                `OFF_IRQ_MASK: begin
                    next_rdData = maskAll[byteBase +: 8];
                end
                default: begin
                    next_rdData = 8'h00;
                end
            endcase
        end else begin
            case (addr)
                `ADDR_CH0_COUNT_LOW: begin
                    next_rdData = countByte(shownAll[15:0], 1'b0);
                end
                `ADDR_CH0_COUNT_HIGH: begin
                    next_rdData = countByte(shownAll[15:0], 1'b1);
                end
                `ADDR_JITTER_CONFIG: begin
                    next_rdData = {5'h00, jitterCfg};
                end
                `ADDR_POS_PEAK_LOW: begin
                    next_rdData = posPeak[7:0];
                end
                `ADDR_POS_PEAK_HIGH: begin
                    next_rdData = peakHighByte(posPeak);
                end
                `ADDR_NEG_PEAK_LOW: begin
                    next_rdData = negPeak[7:0];
                end
                `ADDR_NEG_PEAK_HIGH: begin
                    next_rdData = peakHighByte(negPeak);
                end
                `ADDR_CH0_COUNT_CTRL: begin
                    next_rdData = ctrlByte(cntModeAll[0]);
                end
                default: begin
                    next_rdData = 8'h00;
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            rdData <= next_rdData;
        end else begin
            rdData <= 8'h00;
        end
    end

endmodule

// *** tb/line_error_jitter_chk.sv ***
`timescale 1ns/1ps
module line_error_jitter_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [10:0] addr,
    input wire logic [7:0]  wrData,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [7:0]  rdData,
    input wire logic [15:0] singleBipolarViolation,
    input wire logic [15:0] lineBipolarViolation,
    input wire logic [15:0] singleExcessZeros,
    input wire logic [15:0] lineExcessZeros,
    input wire logic [15:0] patternError,
    input wire logic [16:0] errorEvent,
    input wire logic        measBandwidthSelect,
    input wire logic        measPeriodMode,
    input wire logic        measPeriodEnd,
    input wire logic        irq
);
    wire anyEv = |{singleBipolarViolation, lineBipolarViolation, singleExcessZeros, lineExcessZeros, patternError};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_ev_status;
        rdStrobe && addr == 11'h022 && $past(singleBipolarViolation[0]) |=> rdData[5];
    endproperty
    a_ev_status: assert property (p_ev_status) else $error("bipolar event not latched");
    property p_status_res;
        rdStrobe && addr[5:0] == 6'h22 |=> rdData[7:6] == 2'b00;
    endproperty
    a_status_res: assert property (p_status_res) else $error("reserved status bits set");
    property p_irq_rise;
        $rose(irq) |-> $past(anyEv) || $past(wrStrobe) || $past(|errorEvent, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(wrStrobe);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    property p_cfg_res;
        rdStrobe && addr == 11'h7e5 |=> rdData[7:3] == 5'h00;
    endproperty
    a_cfg_res: assert property (p_cfg_res) else $error("reserved config bits set");
    property p_cfg_out;
        wrStrobe && addr == 11'h7e5 |=> measBandwidthSelect == $past(wrData[0]) && measPeriodMode == $past(wrData[1]);
    endproperty
    a_cfg_out: assert property (p_cfg_out) else $error("config outputs wrong");
    property p_period_end;
        measPeriodEnd && !measPeriodMode |-> $past(wrStrobe, 2) && $past(wrData[2], 2) && $past(addr, 2) == 11'h7e5;
    endproperty
    a_period_end: assert property (p_period_end) else $error("capture without stop edge");
    property p_end_pulse;
        measPeriodEnd |=> !measPeriodEnd;
    endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("capture pulse too long");
    property p_peak_hi;
        rdStrobe && (addr == 11'h7e7 || addr == 11'h7e9) |=> rdData[7:4] == 4'h0;
    endproperty
    a_peak_hi: assert property (p_peak_hi) else $error("peak high reserved bits set");
endmodule

bind line_error_jitter_status_regs line_error_jitter_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .singleBipolarViolation(singleBipolarViolation), .lineBipolarViolation(lineBipolarViolation),
    .singleExcessZeros(singleExcessZeros), .lineExcessZeros(lineExcessZeros), .patternError(patternError),
    .errorEvent(errorEvent), .measBandwidthSelect(measBandwidthSelect), .measPeriodMode(measPeriodMode),
    .measPeriodEnd(measPeriodEnd), .irq(irq));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        sys_clk;
    logic        sys_rst;
    logic [10:0] addr;
    logic [7:0]  wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    wire  [7:0]  rdData;
    logic [4:0]  ev;
    logic [16:0] errorEvent;
    logic [11:0] posPeakIn;
    logic [11:0] negPeakIn;
    wire         measBandwidthSelect;
    wire         measPeriodMode;
    wire         measPeriodEnd;
    wire         irq;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          i;

    // Short rounds keep auto updates visible; long jitter period keeps auto captures out of the way
    line_error_jitter_status_regs #(.ROUND_CYCLES(27'd20), .JITTER_CYCLES(27'd1000)) uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .singleBipolarViolation({15'h0000, ev[4]}),
        .lineBipolarViolation({15'h0000, ev[3]}), .singleExcessZeros({15'h0000, ev[2]}),
        .lineExcessZeros({15'h0000, ev[1]}), .patternError({15'h0000, ev[0]}), .errorEvent(errorEvent),
        .posPeakIn(posPeakIn), .negPeakIn(negPeakIn), .measBandwidthSelect(measBandwidthSelect),
        .measPeriodMode(measPeriodMode), .measPeriodEnd(measPeriodEnd), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task wrap_up;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
    endtask

    // Caller is just past an edge; data is looked at only in the one cycle it stands
    task rd_now(input logic [10:0] a, input logic [7:0] e);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, e);
    endtask

    task rd(input logic [10:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        rd_now(a, e);
    endtask

    // Read right behind the pulse so the latch itself is seen, not a later side effect
    task evt(input int idx, input logic [7:0] e);
        @(posedge sys_clk);
        ev <= 5'h01 << idx;
        @(posedge sys_clk);
        ev <= 5'h00;
        rd_now(11'h022, e);
    endtask

    task burst(input int ch, input int n);
        @(posedge sys_clk);
        errorEvent <= 17'h00001 << ch;
        repeat (n) @(posedge sys_clk);
        errorEvent <= 17'h00000;
    endtask

    initial begin
        #(80000 * 8);
        n_mismatch++;
        wrap_up;
    end

    initial begin
        sys_rst = 1'b1;
        addr = 11'h000;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        ev = 5'h00;
        errorEvent = 17'h00000;
        posPeakIn = 12'habc;
        negPeakIn = 12'h123;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(11'h022, 8'h00);
        rd(11'h023, 8'h00);
        rd(11'h024, 8'h00);
        rd(11'h7e3, 8'h00);
        rd(11'h7e4, 8'h00);
        rd(11'h7e5, 8'h00);
        rd(11'h7e7, 8'h00);
        rd(11'h03f, 8'h3f);
        rd(11'h025, 8'h00);
        for (i = 0; i < 5; i++) begin
            evt(i, 8'h02 << i);
            chk({7'h00, irq}, 8'h01);
            wr(11'h022, 8'h00);
            rd(11'h022, 8'h02 << i);
            wr(11'h022, 8'h02 << i);
            rd(11'h022, 8'h00);
            chk({7'h00, irq}, 8'h00);
        end
        wr(11'h03f, 8'h00);
        evt(4, 8'h20);
        chk({7'h00, irq}, 8'h00);
        wr(11'h03f, 8'h3f);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr(11'h022, 8'hff);
        rd(11'h022, 8'h00);
        wr(11'h07e, 8'h00);
        burst(2, 3);
        wr(11'h07e, 8'h01);
        rd(11'h063, 8'h03);
        rd(11'h064, 8'h00);
        wr(11'h063, 8'hff);
        rd(11'h063, 8'h03);
        wr(11'h7ea, 8'h00);
        burst(0, 5);
        wr(11'h7ea, 8'h01);
        rd(11'h7e3, 8'h05);
        wr(11'h07e, 8'h02);
        repeat (25) @(posedge sys_clk);
        rd(11'h063, 8'h00);
        wr(11'h7e5, 8'h04);
        rd(11'h7e6, 8'hbc);
        rd(11'h7e7, 8'h0a);
        rd(11'h7e8, 8'h23);
        rd(11'h7e9, 8'h01);
        wr(11'h7e5, 8'h00);
        posPeakIn <= 12'h456;
        wr(11'h7e5, 8'h02);
        #1;
        chk({7'h00, measPeriodMode}, 8'h01);
        wr(11'h7e5, 8'h06);
        repeat (4) @(posedge sys_clk);
        rd(11'h7e6, 8'hbc);
        wr(11'h7e5, 8'hff);
        rd(11'h7e5, 8'h07);
        chk({7'h00, measBandwidthSelect}, 8'h01);
        // Overflow needs the full 16-bit span, the longest stretch of the run
        wr(11'h03e, 8'h00);
        burst(1, 65536);
        repeat (3) @(posedge sys_clk);
        rd(11'h022, 8'h01);
        chk({7'h00, irq}, 8'h01);
        wr(11'h03e, 8'h01);
        rd(11'h023, 8'hff);
        rd(11'h024, 8'hff);
        wrap_up;
    end
endmodule
